// ---- dv/lpd_link_assertions.sv ----
// checker for the first link and the receiver word timing
// assumes one clock; signals come straight from the bench top
`timescale 1ns/10ps
`default_nettype none
module lpd_link_assertions (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic link_clk,
  input wire logic [3:0] serial_lane,
  input wire logic [27:0] parallel_out_bit_out,
  input wire logic word_valid_out,
  input wire logic link_locked_out
);
  logic clk_d_reg;
  logic [3:0] ph_reg;
  logic [6:0][3:0] cap_reg;
  logic [6:0][3:0] word_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // phase since the last link clock rise; lanes caught mid-cell
  always_ff @(posedge clk_in) begin
    clk_d_reg <= link_clk;
    ph_reg <= (link_clk && !clk_d_reg) ? 4'h1 : ph_reg + 4'h1;
    if (ph_reg[0] && ph_reg < 4'hd) begin
      cap_reg[ph_reg[3:1]] <= serial_lane;
    end
    if (ph_reg == 4'hd) begin
      word_reg <= {serial_lane, cap_reg[5:0]};
    end
  end

  // each lane holds a bit for two cycles, seven bits a period
  sequence s_cells;
    ##1 $stable(serial_lane) ##2 $stable(serial_lane) ##2 $stable(serial_lane)
    ##2 $stable(serial_lane) ##2 $stable(serial_lane) ##2 $stable(serial_lane)
    ##2 $stable(serial_lane);
  endsequence
  sequence s_high7;
    link_clk [*7] ##1 !link_clk;
  endsequence

  a_clock_high_seven: assert property ($rose(link_clk) |-> s_high7)
    else $error("link clock high time wrong");
  a_clock_low_seven: assert property ($fell(link_clk) |-> !link_clk [*7] ##1 link_clk)
    else $error("link clock low time wrong");
  a_lane_cell_hold: assert property ($rose(link_clk) |-> s_cells)
    else $error("lane changed mid-cell");
  a_word_after_edge: assert property ($rose(link_clk) && link_locked_out |->
    ##[15:19] word_valid_out)
    else $error("no word after link period");
  a_valid_one_cycle: assert property (word_valid_out |=> !word_valid_out [*8])
    else $error("word valid too long or too often");
  a_valid_needs_lock: assert property (word_valid_out |-> link_locked_out)
    else $error("word valid without lock");
  a_word_from_lanes: assert property (word_valid_out |->
    parallel_out_bit_out[0] == word_reg[0][0] && parallel_out_bit_out[27] == word_reg[0][3]
    && parallel_out_bit_out[5] == word_reg[1][3] && parallel_out_bit_out[24] == word_reg[4][2]
    && parallel_out_bit_out[23] == word_reg[6][3]
    && parallel_out_bit_out[18] == word_reg[6][1])
    else $error("output word differs from lanes");
  a_lock_in_time: assert property ($rose(rst_b_in) |-> ##[1:80] link_locked_out)
    else $error("link never locked");
  a_reset_clears: assert property (disable iff (1'b0) !rst_b_in |=>
    !link_clk && serial_lane == 4'h0 && !word_valid_out && !link_locked_out)
    else $error("reset left state behind");
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench: four-lane and three-lane link pairs
// assumes the design files and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic msb = 1'b0;
  logic pix_valid = 1'b0;
  logic pv = 1'b0;
  logic hs = 1'b0;
  logic vs = 1'b0;
  logic sp = 1'b0;
  logic [7:0] red = 8'h00;
  logic [7:0] green = 8'h00;
  logic [7:0] blue = 8'h00;
  logic ready;
  logic [27:0] word;
  logic wv, lock, hs_o, vs_o, pv_o, sp_o, sp3_o, lock3;
  logic [7:0] r_o, g_o, b_o, r3_o, g3_o, b3_o;
  int n_fail = 0;
  int compares = 0;
  int full_seen = 0;

  lpd_link_if lpd_link_if_inst ();
  lpd_link_if lpd_link_if_inst_b ();

  // system clock, 8 ns period
  initial begin
    forever #4 clk_in = ~clk_in;
  end

  // four-lane pair under test and the checker beside its link
  lpd_tx lpd_tx_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(lpd_link_if_inst.tx),
    .msb_on_lane3_in(msb), .pix_valid_in(pix_valid), .pix_ready_out(ready), .red_in(red),
    .green_in(green), .blue_in(blue), .hsync_in(hs), .vsync_in(vs), .pixel_valid_in(pv),
    .spare_bit_in(sp));
  lpd_rx lpd_rx_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(lpd_link_if_inst.rx),
    .msb_on_lane3_in(msb), .parallel_out_bit_out(word), .word_valid_out(wv), .red_out(r_o),
    .green_out(g_o), .blue_out(b_o), .hsync_out(hs_o), .vsync_out(vs_o),
    .pixel_valid_out(pv_o), .spare_bit_out(sp_o), .link_locked_out(lock));
  lpd_link_assertions lpd_link_assertions_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .link_clk(lpd_link_if_inst.link_clk), .serial_lane(lpd_link_if_inst.serial_lane),
    .parallel_out_bit_out(word), .word_valid_out(wv), .link_locked_out(lock));

  // three-lane pair fed the same pixels in lockstep
  lpd_tx #(.LANES(3)) lpd_tx_inst_b (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .link(lpd_link_if_inst_b.tx), .msb_on_lane3_in(msb), .pix_valid_in(pix_valid),
    .pix_ready_out(), .red_in(red), .green_in(green), .blue_in(blue), .hsync_in(hs),
    .vsync_in(vs), .pixel_valid_in(pv), .spare_bit_in(sp));
  lpd_rx #(.LANES(3)) lpd_rx_inst_b (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .link(lpd_link_if_inst_b.rx), .msb_on_lane3_in(msb), .parallel_out_bit_out(),
    .word_valid_out(), .red_out(r3_o), .green_out(g3_o), .blue_out(b3_o), .hsync_out(),
    .vsync_out(), .pixel_valid_out(), .spare_bit_out(sp3_o), .link_locked_out(lock3));

  // count cycles where an offered pixel was stalled
  always @(negedge clk_in) begin
    if (pix_valid && ready === 1'b0) full_seen++;
  end

  task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // offer a pixel and hold it until the buffer takes it
  task automatic push(input logic [23:0] c, input logic [2:0] f);
    {red, green, blue} = c;
    {hs, vs, sp} = f;
    pv = 1'b1;
    pix_valid = 1'b1;
    while (ready !== 1'b1) tick(1);
    tick(1);
  endtask

  // wait for the next pixel word and judge fields and positions
  task automatic get(input logic [23:0] c, input logic [2:0] f);
    logic [7:0] r;
    logic [3:0] e;
    r = c[23:16];
    e = msb ? {r[6], r[7], r[0], r[5]} : {r[0], r[1], r[2], r[7]};
    do tick(1); while (!(wv === 1'b1 && pv_o === 1'b1));
    chk(28'({r_o, g_o, b_o}), 28'(c));
    chk(28'({hs_o, vs_o, sp_o}), 28'(f));
    chk(28'({word[24], word[25], word[26], word[23]}), 28'({f[2:1], 1'b1, f[0]}));
    chk(28'({word[27], word[5], word[0], word[6]}), 28'(e));
    chk(28'(r3_o), 28'({r[7:2], 2'b00}));
    chk(28'({g3_o, b3_o, sp3_o}), 28'({c[15:10], 2'b00, c[7:2], 2'b00, 1'b0}));
  endtask

  // one pixel in each lane-3 arrangement
  task automatic t_modes;
    logic [23:0] c;
    for (int m = 0; m < 2; m++) begin
      msb = m[0];
      c = m ? 24'h1e7bd2 : 24'h5ac396;
      tick(30);
      push(c, 3'h5);
      pix_valid = 1'b0;
      pv = 1'b0;
      get(c, 3'h5);
    end
  endtask

  // four back to back fill the buffer; words leave in order
  task automatic t_burst;
    full_seen = 0;
    fork
      begin
        for (int i = 0; i < 4; i++) push(24'h814224 + 24'h101112 * 24'(i), 3'(i));
        pix_valid = 1'b0;
        pv = 1'b0;
      end
      for (int i = 0; i < 4; i++) get(24'h814224 + 24'h101112 * 24'(i), 3'(i));
    join
    chk(28'(full_seen > 0), 28'h1);
  endtask

  // an empty period still sends a zero word
  task automatic t_idle;
    do tick(1); while (wv !== 1'b1);
    chk(word, 28'h0);
    chk(28'(lpd_link_if_inst.serial_lane), 28'h0);
  endtask

  // link clock rises once each fourteen cycles
  task automatic t_rate;
    int n;
    logic prev;
    n = 0;
    repeat (140) begin
      prev = lpd_link_if_inst.link_clk;
      tick(1);
      if (lpd_link_if_inst.link_clk && !prev) n++;
    end
    chk(28'(n), 28'h0a);
  endtask

  // reset mid-run clears the link, then it locks again
  task automatic t_reset;
    rst_b_in = 1'b0;
    tick(2);
    chk(28'({lock, lock3, wv, ready, lpd_link_if_inst.link_clk}), 28'h2);
    rst_b_in = 1'b1;
    tick(80);
    chk(28'({lock, lock3}), 28'h3);
  endtask

  // main sequence
  initial begin
    tick(8);
    rst_b_in = 1'b1;
    tick(80);
    chk(28'({lock, lock3}), 28'h3);
    t_modes();
    t_burst();
    t_idle();
    t_rate();
    t_reset();
    t_modes();
    stop_test();
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk_in);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire

// ---- hw/lpd_link_if.sv ----
// the serial pixel link: forwarded clock and four data lanes
// assumes both ends share the system clock; lanes are one-way
`timescale 1ns/10ps
`default_nettype none
interface lpd_link_if;
  logic link_clk;
  logic [3:0] serial_lane;

  // transmitter end drives clock and lanes
  modport tx (output link_clk, output serial_lane);
  // receiver end only listens
  modport rx (input link_clk, input serial_lane);
endinterface
`default_nettype wire

// ---- hw/lpd_pkg.sv ----
// shared constants and mapping helpers for the serial pixel link
// assumes both ends run on one 125 MHz system clock
package lpd_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int LINK_MIN_MHZ = 20;
  localparam int LINK_MAX_MHZ = 85;
  localparam int BITS_PER_LANE = 7;
  localparam int LANES_MAX = 4;
  localparam int WORD_BITS = 28;
  localparam int CELL_CYCLES = 2;
  localparam int PERIOD_CYCLES = BITS_PER_LANE * CELL_CYCLES;
  localparam int LINK_PERIOD_NS = PERIOD_CYCLES * CLK_PERIOD_NS;
  localparam int STROBE_OFFSET = CELL_CYCLES / 2;
  localparam int LOCK_TIMEOUT = 2 * PERIOD_CYCLES;
  localparam int HS_POS = 24;
  localparam int VS_POS = 25;
  localparam int PIXEL_VALID_POS = 26;
  localparam int SP_POS = 23;

  // stream position carried in each lane slot, index lane*7+slot
  localparam logic [139:0] LANE_POS = {
    5'h17, 5'h11, 5'h10, 5'h0b, 5'h0a, 5'h05, 5'h1b,
    5'h1a, 5'h19, 5'h18, 5'h16, 5'h15, 5'h14, 5'h13,
    5'h12, 5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h09, 5'h08,
    5'h07, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
  // positions of the six colour bits on lanes 0-2, index colour*6+k
  localparam logic [89:0] SIX_POS = {
    5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h0f,
    5'h0e, 5'h0d, 5'h0c, 5'h09, 5'h08, 5'h07,
    5'h06, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
  // positions of the two colour bits on lane 3, index colour*2+k
  localparam logic [29:0] TWO_POS = {
    5'h11, 5'h10, 5'h0b, 5'h0a, 5'h05, 5'h1b};

  typedef logic [2:0][7:0] lpd_col_t;

  // stream position of a lane slot
  function automatic logic [4:0] lane_pos(input int lane, input int slot);
    return LANE_POS[(lane * BITS_PER_LANE + slot) * 5 +: 5];
  endfunction

  // colour and control into a stream word
  function automatic logic [27:0] pack_word(input lpd_col_t col, input logic hs,
      input logic vs, input logic pv, input logic sp, input logic msb);
    logic [27:0] w;
    w = '0;
    for (int i = 0; i < 3; i++) begin
      for (int k = 0; k < 6; k++) begin
        w[SIX_POS[(i * 6 + k) * 5 +: 5]] = msb ? col[i][k] : col[i][k + 2];
      end
      for (int k = 0; k < 2; k++) begin
        w[TWO_POS[(i * 2 + k) * 5 +: 5]] = msb ? col[i][k + 6] : col[i][k];
      end
    end
    w[HS_POS] = hs;
    w[VS_POS] = vs;
    w[PIXEL_VALID_POS] = pv;
    w[SP_POS] = sp;
    return w;
  endfunction

  // stream word back into colours, index 0 red, 1 green, 2 blue
  function automatic lpd_col_t unpack_col(input logic [27:0] w, input logic msb);
    lpd_col_t col;
    logic [5:0] six;
    logic [1:0] two;
    col = '0;
    for (int i = 0; i < 3; i++) begin
      for (int k = 0; k < 6; k++) begin
        six[k] = w[SIX_POS[(i * 6 + k) * 5 +: 5]];
      end
      for (int k = 0; k < 2; k++) begin
        two[k] = w[TWO_POS[(i * 2 + k) * 5 +: 5]];
      end
      col[i] = msb ? {two, six} : {six, two};
    end
    return col;
  endfunction

endpackage

// ---- hw/lpd_rx.sv ----
// deserializing receiver end of the pixel link
// assumes link pins come from outside; both are synchronised first
`timescale 1ns/10ps
`default_nettype none
module lpd_rx #(
  parameter int LANES = 4
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  lpd_link_if.rx link,
  input wire logic msb_on_lane3_in,
  output logic [27:0] parallel_out_bit_out,
  output logic word_valid_out,
  output logic [7:0] red_out,
  output logic [7:0] green_out,
  output logic [7:0] blue_out,
  output logic hsync_out,
  output logic vsync_out,
  output logic pixel_valid_out,
  output logic spare_bit_out,
  output logic link_locked_out
);
  localparam int PW = $clog2(lpd_pkg::PERIOD_CYCLES + 1);
  localparam int TW = $clog2(lpd_pkg::LOCK_TIMEOUT + 1);

  typedef enum logic [1:0] {
    LPD_HUNT = 2'b00,
    LPD_LOCK = 2'b01,
    LPD_LOST = 2'b10
  } lpd_lock_e;

  lpd_lock_e lock_reg;
  lpd_lock_e lock_next;
  logic clk_s1_reg;
  logic clk_s2_reg;
  logic clk_s3_reg;
  logic [3:0] lane_s1_reg;
  logic [3:0] lane_s2_reg;
  logic rise;
  logic [PW-1:0] phase_reg;
  logic [PW-1:0] phase_now;
  logic [TW-1:0] idle_reg;
  logic strobe;
  logic [2:0] slot;
  logic [6:0] cap_reg [lpd_pkg::LANES_MAX];
  logic done_reg;
  logic [27:0] word;
  logic msb_eff;
  lpd_pkg::lpd_col_t col;

  // two flip-flops on every pin before any logic reads it
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      lane_s1_reg <= '0;
      lane_s2_reg <= '0;
    end else begin
      clk_s1_reg <= link.link_clk;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      lane_s1_reg <= link.serial_lane;
      lane_s2_reg <= lane_s1_reg;
    end
  end

  // rising edge of the forwarded clock marks cell 0 of a period
  assign rise = clk_s2_reg && !clk_s3_reg;
  assign phase_now = rise ? '0 : phase_reg;

  // phase within the period, held at the end when the clock stops
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      phase_reg <= PW'(lpd_pkg::PERIOD_CYCLES);
    end else if (phase_now < PW'(lpd_pkg::PERIOD_CYCLES)) begin
      phase_reg <= phase_now + PW'(1);
    end else begin
      phase_reg <= phase_reg;
    end
  end

  // strobe in the middle of each bit cell
  assign strobe = (phase_now < PW'(lpd_pkg::PERIOD_CYCLES)) &&
      ((phase_now % PW'(lpd_pkg::CELL_CYCLES)) == PW'(lpd_pkg::STROBE_OFFSET));
  assign slot = 3'(phase_now / PW'(lpd_pkg::CELL_CYCLES));

  // seven bits captured per lane per period
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      for (int l = 0; l < lpd_pkg::LANES_MAX; l++) begin
        cap_reg[l] <= '0;
      end
    end else if (strobe) begin
      for (int l = 0; l < lpd_pkg::LANES_MAX; l++) begin
        // a three-lane receiver ignores lane 3 entirely
        cap_reg[l][slot] <= (l < LANES) && lane_s2_reg[l];
      end
    end
  end

  // last strobe of the period closes the word
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= strobe && (slot == 3'(lpd_pkg::BITS_PER_LANE - 1));
    end
  end

  // lane slots back into stream positions
  always_comb begin
    word = '0;
    for (int l = 0; l < lpd_pkg::LANES_MAX; l++) begin
      for (int s = 0; s < lpd_pkg::BITS_PER_LANE; s++) begin
        word[lpd_pkg::lane_pos(l, s)] = cap_reg[l][s];
      end
    end
  end

  // 18 bpp forces the low-order arrangement
  assign msb_eff = (LANES == 4) ? msb_on_lane3_in : 1'b0;
  assign col = lpd_pkg::unpack_col(word, msb_eff);

  // parallel word, one update per link period
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      parallel_out_bit_out <= '0;
    end else if (done_reg) begin
      parallel_out_bit_out <= word;
    end
  end

  // colour and control fields, updated with the word
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      red_out <= '0;
      green_out <= '0;
      blue_out <= '0;
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
      pixel_valid_out <= 1'b0;
      spare_bit_out <= 1'b0;
    end else if (done_reg) begin
      red_out <= col[0];
      green_out <= col[1];
      blue_out <= col[2];
      hsync_out <= word[lpd_pkg::HS_POS];
      vsync_out <= word[lpd_pkg::VS_POS];
      pixel_valid_out <= word[lpd_pkg::PIXEL_VALID_POS];
      spare_bit_out <= (LANES == 4) && word[lpd_pkg::SP_POS];
    end
  end

  // word pulse only while locked to a running clock
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      word_valid_out <= 1'b0;
    end else begin
      word_valid_out <= done_reg && (lock_reg == LPD_LOCK);
    end
  end

  // cycles since the last clock edge
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      idle_reg <= '0;
    end else if (rise) begin
      idle_reg <= '0;
    end else if (idle_reg != TW'(lpd_pkg::LOCK_TIMEOUT)) begin
      idle_reg <= idle_reg + TW'(1);
    end else begin
      idle_reg <= idle_reg;
    end
  end

  // lock tracking: a period must pass between edges at the divider rate
  always_comb begin
    lock_next = lock_reg;
    case (lock_reg)
      LPD_HUNT: begin
        if (rise) begin
          lock_next = LPD_LOCK;
        end
      end
      LPD_LOCK: begin
        if (idle_reg == TW'(lpd_pkg::LOCK_TIMEOUT)) begin
          lock_next = LPD_LOST;
        end else if (rise && (phase_reg != PW'(lpd_pkg::PERIOD_CYCLES))) begin
          lock_next = LPD_LOST; // edge arrived early: wrong rate
        end
      end
      LPD_LOST: begin
        lock_next = LPD_HUNT;
      end
      default: begin
        lock_next = LPD_HUNT;
      end
    endcase
  end

  // lock state register
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      lock_reg <= LPD_HUNT;
    end else begin
      lock_reg <= lock_next;
    end
  end

  assign link_locked_out = (lock_reg == LPD_LOCK);
endmodule
`default_nettype wire

// ---- hw/lpd_tx.sv ----
// serializing transmitter end of the pixel link
// assumes user logic on clk_in; derives the link clock by a divider
`timescale 1ns/10ps
`default_nettype none
module lpd_tx #(
  parameter int LANES = 4,
  parameter int DEPTH = 2,
  parameter int WIDTH = 28
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  lpd_link_if.tx link,
  input wire logic msb_on_lane3_in,
  input wire logic pix_valid_in,
  output logic pix_ready_out,
  input wire logic [7:0] red_in,
  input wire logic [7:0] green_in,
  input wire logic [7:0] blue_in,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic pixel_valid_in,
  input wire logic spare_bit_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int PW = $clog2(lpd_pkg::PERIOD_CYCLES);

  logic [WIDTH-1:0] buf_mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [PW-1:0] phase_reg;
  logic [PW-1:0] phase_next;
  logic [WIDTH-1:0] cur_reg;
  logic [WIDTH-1:0] send_word;
  logic [3:0] lane_reg;
  logic link_clk_reg;
  logic push;
  logic pop;
  logic period_end;
  logic msb_eff;
  logic [2:0] slot_next;

  // 18 bpp runs on the low-order arrangement only
  assign msb_eff = (LANES == 4) ? msb_on_lane3_in : 1'b0;
  assign pix_ready_out = (count_reg != (AW + 1)'(DEPTH));
  assign push = pix_valid_in && pix_ready_out;
  assign period_end = (phase_reg == PW'(lpd_pkg::PERIOD_CYCLES - 1));
  assign pop = period_end && (count_reg != '0);
  assign phase_next = period_end ? '0 : phase_reg + PW'(1);
  assign slot_next = 3'(phase_next / PW'(lpd_pkg::CELL_CYCLES));
  // a new word starts each period; idle periods send zeros
  assign send_word = period_end ? (pop ? buf_mem[rd_ptr_reg] : '0) : cur_reg;

  // buffer write side
  always_ff @(posedge clk_in) begin
    if (push) begin
      buf_mem[wr_ptr_reg] <= WIDTH'(lpd_pkg::pack_word({blue_in, green_in, red_in},
          hsync_in, vsync_in, pixel_valid_in, spare_bit_in, msb_eff));
    end
  end

  // buffer pointers and fill count
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // period divider: seven bit cells per link clock period
  // reset parks at the period end so the first period after release is full
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      phase_reg <= PW'(lpd_pkg::PERIOD_CYCLES - 1);
      cur_reg <= '0;
    end else begin
      phase_reg <= phase_next;
      cur_reg <= send_word;
    end
  end

  // link clock high in the first half period, bit n launched at cell n
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      link_clk_reg <= 1'b0;
      lane_reg <= '0;
    end else begin
      link_clk_reg <= (phase_next < PW'(lpd_pkg::PERIOD_CYCLES / 2));
      for (int l = 0; l < lpd_pkg::LANES_MAX; l++) begin
        lane_reg[l] <= (l < LANES) && send_word[lpd_pkg::lane_pos(l, int'(slot_next))];
      end
    end
  end

  assign link.link_clk = link_clk_reg;
  assign link.serial_lane = lane_reg;
endmodule
`default_nettype wire
